//--- smr_chk.sv
/*
  concurrent checks on the supply monitor top ports.
  assumes the option byte only changes while reset is held.
*/
`timescale 1ns/10ps
module smr_chk (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_cmp_upper,
  input wire logic i_cmp_lower,
  input wire logic i_cmp_single,
  input wire logic i_cmp_mon1,
  input wire logic [7:0] i_option_byte,
  input wire logic o_int_rstn,
  input wire logic o_detect_irq_pulse,
  input wire logic o_mon1_irq_pulse
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  wire logic en = i_option_byte[0];
  wire logic ir = en && i_option_byte[2:1] == 2'h0 && !i_option_byte[3];
  wire logic ro = en && i_option_byte[2:1] == 2'h1 && !i_option_byte[3];
  wire logic cr = en && i_option_byte[2:1] == 2'h1 && i_option_byte[3];
  wire logic io = en && i_option_byte[2];
  ////////////////////////////////////////////////////////////////////////////
  // release must not come early: hold low well into the count
  sequence s_cnt_hold;
    ##1 !o_int_rstn [*8] ##20 !o_int_rstn;
  endsequence
  AST_IR_RELEASE: assert property (ir && $rose(i_cmp_upper) && i_cmp_lower |-> ##[1:4] o_int_rstn)
    else $error("reset not released on rise to upper level");
  AST_IR_ASSERT: assert property (ir && $fell(i_cmp_lower) |-> ##[1:4] !o_int_rstn)
    else $error("reset not asserted on drop below lower level");
  AST_IR_INT: assert property (ir && o_int_rstn && i_cmp_lower && $fell(i_cmp_upper) |-> ##[1:4] o_detect_irq_pulse)
    else $error("no interrupt on drop below upper level");
  AST_CNT: assert property (cr && $rose(i_cmp_single) |-> s_cnt_hold ##[1:12] o_int_rstn)
    else $error("counted release out of window");
  AST_RO: assert property (ro && $changed(i_cmp_single) |-> ##[1:4] (o_int_rstn == i_cmp_single))
    else $error("reset-only mode does not follow single level");
  AST_IO: assert property (io && $changed(i_cmp_single) |-> ##[1:4] o_detect_irq_pulse)
    else $error("missing interrupt on single level crossing");
  AST_MON1: assert property (io && $changed(i_cmp_mon1) |-> ##[1:4] o_mon1_irq_pulse)
    else $error("missing monitor-1 interrupt");
  AST_DIS: assert property (!en |-> !o_detect_irq_pulse && !o_mon1_irq_pulse)
    else $error("event while detector disabled");
  AST_PULSE: assert property (o_detect_irq_pulse || o_mon1_irq_pulse |=> !o_detect_irq_pulse && !o_mon1_irq_pulse)
    else $error("interrupt pulse longer than one cycle");
endmodule // smr_chk
bind smr_top smr_chk u_chk (.i_ref_clk, .i_rstn, .i_cmp_upper, .i_cmp_lower, .i_cmp_single, .i_cmp_mon1,
  .i_option_byte, .o_int_rstn, .o_detect_irq_pulse, .o_mon1_irq_pulse);

//--- smr_pkg.sv
/*
  shared constants and types for the supply monitor reset and interrupt block.
  assumes a single clock domain (the low-speed oscillator clock) and a plain register port.
*/
package smr_pkg;
  // register word offsets
  localparam logic [3:0] ADDR_SETUP = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
  localparam logic [3:0] ADDR_OPTION = 4'h4;

  // setup register fields
  localparam int SETUP_MODE_BIT = 0;
  localparam int SETUP_LEVEL_BIT = 1;

  // option byte fields
  localparam int OPT_ENABLE_BIT = 0;
  localparam int OPT_OPMODE_LSB = 1;
  localparam int OPT_COUNTED_BIT = 3;

  // interrupt status bit positions
  localparam int IRQ_DETECT_BIT = 0;
  localparam int IRQ_MON1_BIT = 1;
  localparam int IRQ_RESET_BIT = 2;
  localparam int IRQ_W = 3;

  // reset values
  localparam logic SETUP_MODE_RST = 1'b0;
  localparam logic SETUP_LEVEL_RST = 1'b0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  // clocks counted before the reset is released in the counted variant
  localparam logic [5:0] RELEASE_COUNT = 6'h20;

  typedef enum logic [1:0] {
    SMR_OP_INT_RESET,
    SMR_OP_RESET,
    SMR_OP_INT
  } smr_opmode_e;
endpackage

//--- smr_supply_model.sv
/*
  analog comparator stand-in: a supply code compared against four levels.
  assumes the bench moves the supply code only right after a clock edge.
*/
`timescale 1ns/10ps
module smr_supply_model #(
  parameter logic [7:0] UPPER_LVL = 8'h30,
  parameter logic [7:0] LOWER_LVL = 8'h20,
  parameter logic [7:0] SINGLE_LVL = 8'h28,
  parameter logic [7:0] MON1_LVL = 8'h38
) (
  input wire logic [7:0] i_supply,
  output logic [3:0] o_cmp
);
  // ordered upper, lower, single, monitor-1; high means at or above
  assign o_cmp = {i_supply >= UPPER_LVL, i_supply >= LOWER_LVL, i_supply >= SINGLE_LVL, i_supply >= MON1_LVL};
endmodule // smr_supply_model

//--- smr_sync.sv
/*
  two-flop synchronisers for the four analog comparator outputs.
  assumes the comparator levels are asynchronous to i_ref_clk.
*/
`timescale 1ns/10ps
module smr_sync (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [3:0] i_cmp,
  smr_sync_if.prod o_sync
);
  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] stable;
  } smr_sync_s;

  smr_sync_s st_r;
  smr_sync_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = i_cmp;
    st_nxt.stable = st_r.meta; // [RULE16]
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_sync.above_upper = st_r.stable[0];
  assign o_sync.above_lower = st_r.stable[1];
  assign o_sync.above_single = st_r.stable[2];
  assign o_sync.above_mon1 = st_r.stable[3];
endmodule // smr_sync

//--- smr_sync_if.sv
/*
  carrier between the top and its comparator synchroniser.
  assumes both sides share the low-speed oscillator clock.
*/
`timescale 1ns/10ps
interface smr_sync_if;
  logic above_upper;
  logic above_lower;
  logic above_single;
  logic above_mon1;
  modport prod (output above_upper, output above_lower, output above_single, output above_mon1);
  modport cons (input above_upper, input above_lower, input above_single, input above_mon1);
endinterface

//--- smr_top.sv
/*
  supply monitor digital control: internal reset and detection interrupts.
  assumes comparator outputs are asynchronous levels (high = supply above that level),
  the option byte is a static level from nonvolatile storage, and the clock is the
  low-speed oscillator.
*/
// The register offsets and strobed register access were decided locally.
// Contract
// RULE1: in interrupt plus reset mode the internal reset is released when the supply rises to the reset level.
// RULE2: in interrupt plus reset mode the internal reset is asserted when the supply drops to the reset level.
// RULE3: in interrupt plus reset mode an interrupt is raised when the supply reaches the interrupt level.
// RULE4: in the counted variant the reset is released only after 32 clocks counted from reaching the monitor-0 level.
// RULE5: with upper and lower levels the internal reset goes high once the supply rises to the upper level.
// RULE6: with upper and lower levels an interrupt is issued when the supply drops below the upper level.
// RULE7: with upper and lower levels the internal reset goes low when the supply drops below the lower level.
// RULE8: a drop below the upper level makes hardware set the mode select bit and the level select bit to one.
// RULE9: if no reset followed such a drop, software writes both bits back to zero.
// RULE10: in reset-only mode the internal reset goes high once the supply reaches the single level.
// RULE11: in reset-only mode the internal reset goes low when the supply drops below the single level.
// RULE12: in interrupt-only mode every falling and rising crossing of the single level gives an interrupt.
// RULE13: the monitor-1 interrupt is raised on both the drop below and the rise back to the monitor-1 level.
// RULE14: in interrupt-only mode the system should stop or hold reset before the supply leaves its range.
// RULE15: level selection and detector enable come from the nonvolatile option byte, not run-time software.
// RULE16: comparator outputs pass a two-flop synchroniser before any decision.
// RULE17: a detection interrupt is a one-cycle pulse per qualifying crossing.
`timescale 1ns/10ps
module smr_top (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_cmp_upper,
  input wire logic i_cmp_lower,
  input wire logic i_cmp_single,
  input wire logic i_cmp_mon1,
  input wire logic [7:0] i_option_byte,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_int_rstn,
  output logic o_detect_irq_pulse,
  output logic o_mon1_irq_pulse,
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // synchronised comparators

  smr_sync_if sync_bus ();

  smr_sync u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_cmp({i_cmp_mon1, i_cmp_single, i_cmp_lower, i_cmp_upper}),
    .o_sync(sync_bus.prod)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [7:0] option;
    logic opt_loaded;
    logic detect_mode_select;
    logic detect_level_select;
    logic prev_upper;
    logic prev_single;
    logic prev_mon1;
    logic [2:0] armed;
    logic [5:0] release_cnt;
    logic int_rstn;
    logic detect_pulse;
    logic mon1_pulse;
    logic [smr_pkg::IRQ_W-1:0] irq_stat;
    logic [smr_pkg::IRQ_W-1:0] irq_mask;
    logic irq;
    logic [7:0] rdata;
  } smr_top_s;

  smr_top_s st_r;
  smr_top_s st_nxt;

  logic detector_enable_bit;
  logic counted_variant;
  smr_pkg::smr_opmode_e opmode;
  logic upper_now;
  logic single_now;
  logic mon1_now;
  logic reset_level_ok;
  logic upper_fall;
  logic single_fall;
  logic single_rise;
  logic mon1_edge;
  logic edges_ok;
  logic ev_detect;
  logic reset_fall;
  logic [smr_pkg::IRQ_W-1:0] events;

  // option byte is frozen after the first enabled cycle so a glitch on the
  // nonvolatile read-out cannot change the mode in service
  assign detector_enable_bit = st_r.option[smr_pkg::OPT_ENABLE_BIT]; // [RULE15]
  assign counted_variant = st_r.option[smr_pkg::OPT_COUNTED_BIT];
  assign upper_now = sync_bus.above_upper;
  assign single_now = sync_bus.above_single;
  assign mon1_now = sync_bus.above_mon1;
  // sync stages and prev copies start at zero, so edges seen before they hold real
  // samples would raise a false interrupt right after reset
  assign edges_ok = st_r.armed[2];

  always_comb begin
    case (st_r.option[smr_pkg::OPT_OPMODE_LSB +: 2])
      2'h0: opmode = smr_pkg::SMR_OP_INT_RESET;
      2'h1: opmode = smr_pkg::SMR_OP_RESET;
      default: opmode = smr_pkg::SMR_OP_INT;
    endcase
  end

  assign upper_fall = st_r.prev_upper & ~upper_now & edges_ok;
  assign single_fall = st_r.prev_single & ~single_now & edges_ok;
  assign single_rise = ~st_r.prev_single & single_now & edges_ok;
  assign mon1_edge = (st_r.prev_mon1 ^ mon1_now) & edges_ok; // [RULE13]

  ////////////////////////////////////////////////////////////////////////////////
  // reset level and detection events

  always_comb begin
    reset_level_ok = 1'b1;
    ev_detect = 1'b0;
    case (opmode)
      smr_pkg::SMR_OP_INT_RESET: begin
        // reset follows the lower comparator once the upper level has released it
        if (st_r.int_rstn) begin
          reset_level_ok = sync_bus.above_lower; // [RULE2] [RULE7]
        end else begin
          reset_level_ok = upper_now; // [RULE1] [RULE5]
        end
        ev_detect = upper_fall; // [RULE3] [RULE6]
      end
      smr_pkg::SMR_OP_RESET: begin
        reset_level_ok = single_now; // [RULE10] [RULE11]
      end
      smr_pkg::SMR_OP_INT: begin
        // reset is left to the external reset pin in this mode
        ev_detect = single_fall | single_rise; // [RULE12]
      end
      default: begin
        reset_level_ok = 1'b1;
      end
    endcase
    if (!detector_enable_bit) begin
      reset_level_ok = 1'b1;
      ev_detect = 1'b0;
    end
  end

  assign reset_fall = st_r.int_rstn & ~reset_level_ok;

  always_comb begin
    events = '0;
    events[smr_pkg::IRQ_DETECT_BIT] = ev_detect;
    events[smr_pkg::IRQ_MON1_BIT] = mon1_edge & detector_enable_bit;
    events[smr_pkg::IRQ_RESET_BIT] = reset_fall;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt = st_r;

    if (!st_r.opt_loaded) begin
      st_nxt.option = i_option_byte; // [RULE15]
      st_nxt.opt_loaded = 1'b1;
    end

    st_nxt.prev_upper = upper_now;
    st_nxt.prev_single = single_now;
    st_nxt.prev_mon1 = mon1_now;
    st_nxt.armed = {st_r.armed[1:0], 1'b1};

    // internal reset with optional counted release; held low until the mode is known,
    // otherwise a disabled-looking empty option would release it for one cycle
    if (!st_r.opt_loaded) begin
      st_nxt.int_rstn = 1'b0;
    end else if (!reset_level_ok) begin
      st_nxt.int_rstn = 1'b0;
      st_nxt.release_cnt = '0;
    end else if (!st_r.int_rstn) begin
      if (!counted_variant) begin
        st_nxt.int_rstn = 1'b1;
      end else if (st_r.release_cnt == smr_pkg::RELEASE_COUNT - 6'h01) begin
        st_nxt.int_rstn = 1'b1; // [RULE4]
        st_nxt.release_cnt = '0;
      end else begin
        st_nxt.release_cnt = st_r.release_cnt + 6'h01; // [RULE4]
      end
    end

    // one pulse per crossing because edges are taken on the synchronised level
    st_nxt.detect_pulse = ev_detect; // [RULE17]
    st_nxt.mon1_pulse = events[smr_pkg::IRQ_MON1_BIT]; // [RULE17]

    // software write of setup bits, hardware set wins afterwards
    if (i_wr && i_addr == smr_pkg::ADDR_SETUP) begin
      st_nxt.detect_mode_select = i_wdata[smr_pkg::SETUP_MODE_BIT]; // [RULE9]
      st_nxt.detect_level_select = i_wdata[smr_pkg::SETUP_LEVEL_BIT]; // [RULE9]
    end
    if (opmode == smr_pkg::SMR_OP_INT_RESET && ev_detect) begin
      st_nxt.detect_mode_select = 1'b1; // [RULE8]
      st_nxt.detect_level_select = 1'b1; // [RULE8]
    end

    if (i_wr && i_addr == smr_pkg::ADDR_IRQ_MASK) begin
      st_nxt.irq_mask = i_wdata[smr_pkg::IRQ_W-1:0];
    end
    // write one to clear, a simultaneous event keeps the bit set
    st_nxt.irq_stat = st_r.irq_stat;
    if (i_wr && i_addr == smr_pkg::ADDR_IRQ_STAT) begin
      st_nxt.irq_stat = st_r.irq_stat & ~i_wdata[smr_pkg::IRQ_W-1:0];
    end
    st_nxt.irq_stat = st_nxt.irq_stat | events;
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);

    st_nxt.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        smr_pkg::ADDR_SETUP: begin
          st_nxt.rdata[smr_pkg::SETUP_MODE_BIT] = st_r.detect_mode_select;
          st_nxt.rdata[smr_pkg::SETUP_LEVEL_BIT] = st_r.detect_level_select;
        end
        smr_pkg::ADDR_STATUS: begin
          st_nxt.rdata = {2'h0, st_r.release_cnt == 6'h00 ? 1'b0 : 1'b1, mon1_now,
                          single_now, sync_bus.above_lower, upper_now, st_r.int_rstn};
        end
        smr_pkg::ADDR_IRQ_STAT: st_nxt.rdata[smr_pkg::IRQ_W-1:0] = st_r.irq_stat;
        smr_pkg::ADDR_IRQ_MASK: st_nxt.rdata[smr_pkg::IRQ_W-1:0] = st_r.irq_mask;
        smr_pkg::ADDR_OPTION: st_nxt.rdata = st_r.option;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      st_r <= '0;
      st_r.detect_mode_select <= smr_pkg::SETUP_MODE_RST;
      st_r.detect_level_select <= smr_pkg::SETUP_LEVEL_RST;
      st_r.irq_mask <= smr_pkg::IRQ_MASK_RST;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata = st_r.rdata;
  assign o_int_rstn = st_r.int_rstn;
  assign o_detect_irq_pulse = st_r.detect_pulse;
  assign o_mon1_irq_pulse = st_r.mon1_pulse;
  assign o_irq = st_r.irq;

endmodule // smr_top

//--- testbench.sv
/*
  self-checking bench: one task per operating mode of the supply monitor.
  assumes smr_supply_model drives the comparators from a supply code.
*/
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, ce = 1'b1, int_rstn, det, mon1, irq;
  logic [3:0] addr = 4'h0, cmp;
  logic [7:0] wd = 8'h00, opt = 8'h00, sup = 8'h40, rdata;
  int det_cnt = 0, mon1_cnt = 0, bad_count = 0, n_compared = 0, d0, m0;
  smr_supply_model u_sup (.i_supply(sup), .o_cmp(cmp));
  smr_top u_dut (.i_ref_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_cmp_upper(cmp[3]), .i_cmp_lower(cmp[2]),
    .i_cmp_single(cmp[1]), .i_cmp_mon1(cmp[0]), .i_option_byte(opt), .i_addr(addr), .i_wdata(wd),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_int_rstn(int_rstn), .o_detect_irq_pulse(det),
    .o_mon1_irq_pulse(mon1), .o_irq(irq));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    det_cnt <= det_cnt + (det === 1'b1);
    mon1_cnt <= mon1_cnt + (mon1 === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // option byte and starting supply are set only while reset is held, as smr_chk assumes
  task automatic go(input logic [7:0] o, input logic [7:0] s);
    rstn <= 1'b0; opt <= o; sup <= s; tick(6); rstn <= 1'b1; tick(8);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    wr <= 1'b1; addr <= a; wd <= d; tick(1); wr <= 1'b0; tick(1);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    rd <= 1'b1; addr <= a; tick(1); rd <= 1'b0; #1 chk("rdata", rdata, e); tick(1);
  endtask
  task automatic wait_rst(input logic v, input int lim);
    for (int i = 0; i < lim && int_rstn !== v; i++) tick(1);
    chk("int_rstn", 8'(int_rstn), 8'(v));
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_int_reset();
    go(8'h01, 8'h40);
    wait_rst(1'b1, 12);
    rchk(smr_pkg::ADDR_IRQ_STAT, 8'h00);
    wr_reg(smr_pkg::ADDR_IRQ_MASK, 8'h01);
    d0 = det_cnt; sup <= 8'h2c; tick(10);
    chk("det_pulses", 8'(det_cnt - d0), 8'h01);
    chk("irq", 8'(irq), 8'h01);
    rchk(smr_pkg::ADDR_SETUP, 8'h03);
    wr_reg(smr_pkg::ADDR_SETUP, 8'h00);
    rchk(smr_pkg::ADDR_SETUP, 8'h00);
    wr_reg(smr_pkg::ADDR_IRQ_MASK, 8'h00); tick(1);
    chk("irq_masked", 8'(irq), 8'h00);
    wr_reg(smr_pkg::ADDR_IRQ_MASK, 8'h01); wr_reg(smr_pkg::ADDR_IRQ_STAT, 8'h01); tick(1);
    chk("irq_cleared", 8'(irq), 8'h00);
    sup <= 8'h10; wait_rst(1'b0, 12);
    sup <= 8'h40; wait_rst(1'b1, 12);
    $display("done int_reset");
  endtask
  task automatic t_reset_only();
    go(8'h03, 8'h2c);
    wait_rst(1'b1, 12);
    rchk(smr_pkg::ADDR_STATUS, 8'h0d);
    sup <= 8'h20; wait_rst(1'b0, 12);
    rchk(smr_pkg::ADDR_IRQ_STAT, 8'h04);
    $display("done reset_only");
  endtask
  task automatic t_int_only();
    go(8'h05, 8'h40);
    rchk(smr_pkg::ADDR_IRQ_STAT, 8'h00);
    d0 = det_cnt; m0 = mon1_cnt;
    sup <= 8'h24; tick(10); sup <= 8'h40; tick(10);
    chk("det_pulses", 8'(det_cnt - d0), 8'h02);
    chk("mon1_pulses", 8'(mon1_cnt - m0), 8'h02);
    chk("int_rstn", 8'(int_rstn), 8'h01);
    $display("done int_only");
  endtask
  task automatic t_counted();
    go(8'h0b, 8'h20);
    sup <= 8'h2c; tick(20);
    chk("early_release", 8'(int_rstn), 8'h00);
    wait_rst(1'b1, 30);
    wr_reg(smr_pkg::ADDR_OPTION, 8'hff);
    rchk(smr_pkg::ADDR_OPTION, 8'h0b);
    $display("done counted");
  endtask
  task automatic t_disabled();
    go(8'h00, 8'h40);
    d0 = det_cnt; sup <= 8'h10; tick(10);
    chk("det_pulses", 8'(det_cnt - d0), 8'h00);
    wait_rst(1'b1, 12);
    rchk(smr_pkg::ADDR_OPTION, 8'h00);
    ce <= 1'b0; wr_reg(smr_pkg::ADDR_IRQ_MASK, 8'h07); ce <= 1'b1;
    rchk(smr_pkg::ADDR_IRQ_MASK, 8'h00);
    rchk(4'h9, 8'h00);
    $display("done disabled");
  endtask
  initial begin
    t_int_reset();
    t_reset_only();
    t_int_only();
    t_counted();
    t_disabled();
    end_sim();
  end
endmodule // testbench
